// ### inc/tkc_pkg.sv
// Constants, register layout and state types for the timekeeper control block.
// Assumes a 100 MHz system clock; times are given in microseconds.
package tkc_pkg;

	// ----------------------------------------
	// Clock rate and line timing
	// ----------------------------------------
	localparam int CLK_MHZ        = 100;
	localparam int RST_DET_US     = 480;     // Least low time taken as a reset pulse
	localparam int INT_LOW_US     = 1200;    // Interrupt low time, inside 960..3840
	localparam int PRES_WAIT_US   = 30;      // High time before presence
	localparam int PRES_LOW_US    = 120;     // Presence low time
	localparam int PRES_HIGH_US   = 30;      // Recovery after presence
	localparam int ACTIVITY_DELAY_SELECT_SHORT_US  = 3500;    // End-of-activity delay, select 0
	localparam int ACTIVITY_DELAY_SELECT_LONG_US   = 123000;  // End-of-activity delay, select 1
	localparam int RST_DET_CYC    = RST_DET_US * CLK_MHZ;
	localparam int INT_LOW_CYC    = INT_LOW_US * CLK_MHZ;
	localparam int PRES_WAIT_CYC  = PRES_WAIT_US * CLK_MHZ;
	localparam int PRES_LOW_CYC   = PRES_LOW_US * CLK_MHZ;
	localparam int PRES_HIGH_CYC  = PRES_HIGH_US * CLK_MHZ;
	localparam int ACTIVITY_DELAY_SELECT_SHORT_CYC = ACTIVITY_DELAY_SELECT_SHORT_US * CLK_MHZ;
	localparam int ACTIVITY_DELAY_SELECT_LONG_CYC  = ACTIVITY_DELAY_SELECT_LONG_US * CLK_MHZ;

	// ----------------------------------------
	// Register offsets, fields, reset values
	// ----------------------------------------
	localparam logic [9:0] ALARM_STATUS_ADDR = 10'h200;
	localparam logic [9:0] TIMER_CONFIG_ADDR = 10'h201;
	localparam int CFG_REALTIME_PROTECT = 0;
	localparam int CFG_INTERVAL_PROTECT = 1;
	localparam int CFG_CYCLE_PROTECT    = 2;
	localparam int CFG_EXPIRE_READ_ONLY = 3;
	localparam int CFG_OSC_ENABLE       = 4;
	localparam int CFG_TIMER_TIMER_AUTO_MANUAL   = 5;
	localparam int CFG_TIMER_STOP_START = 6;
	localparam int CFG_ACTIVITY_ACTIVITY_DELAY_SELECT    = 7;
	localparam int STS_FLAG_LSB         = 0;  // Flags: realtime, interval, cycle
	localparam int STS_IEN_LSB          = 3;  // Enables (active low), same order
	localparam logic [7:0] TIMER_CONFIG_RESET = 8'h00;
	localparam logic [2:0] IRQ_ENABLE_N_RESET = 3'h7;
	localparam logic [1:0] COPY_LAST          = 2'h2;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		LN_IDLE, LN_RST_LOW, LN_INT_LOW, LN_RELEASE, LN_PRES_WAIT, LN_PRES_LOW, LN_PRES_HIGH
	} tkc_line_st_t;

	typedef struct packed {
		logic         s1;
		logic         s2;
		logic         s3;
		logic         line_q;
		tkc_line_st_t line_st;
		logic [23:0]  cnt;
		logic [23:0]  act_cnt;
		logic         act_done;
		logic         act_pulse;
		logic [7:0]   cfg;
		logic [2:0]   flags;
		logic [2:0]   ien_n;
		logic [1:0]   copy_cnt;
		logic [7:0]   copy_data;
		logic         expired;
		logic         armed;
		logic         spont_done;
		logic         ext_done;
		logic         pend_at_fall;
		logic         master_rst;
		logic [2:0]   match_q;
		logic         drive_n;
		logic [7:0]   rd_data;
	} tkc_state_t;

	typedef struct packed {
		logic       osc_run;
		logic       interval_run;
		logic [2:0] counter_write_ok;
		logic       mem_write_ok;
		logic       mem_read_ok;
		logic       expired;
		logic       irq_pending;
	} tkc_status_t;

endpackage : tkc_pkg

// ### hw/tkc_control.sv
// Control, write protection, expiration and alarm interrupt signalling of the timekeeper.
// Assumes counters and alarm comparators outside; register port driven by the memory function logic.
`timescale 1ns/1ps

// Behaviour
// - Automatic mode lets the interval timer run while the data line is high.
// - Manual mode runs the interval timer only while stop bit is 0.
// - Oscillator enable gates all counting; it is 0 after reset.
// - Three write-protect flags sit in the low config bits.
// - Expiration occurs when a protected counter reaches its alarm.
// - After expiration, read-only bit chooses reads allowed or identity only.
// - Any protect flag blocks writes to that counter, other flags and read-only bit.
// - With any protect flag set, oscillator enable accepts only ones.
// - Cycle counter protection freezes the delay select bit.
// - Interval protection freezes the mode bit and forces stop bit to 0.
// - Other config bits change by one ordinary copy.
// - Protect flags set only after three copies of one byte, authorization held on the last two.
// - Protect flags set once together; later attempts are refused.
// - Alarms set status flags; a status read clears them all.
// - Interrupt stays pending until the status register is read.
// - Spontaneous interrupt armed by a reset, disarmed by any falling edge.
// - Armed interrupt drives a long low pulse then a presence, once.
// - Alarm during a presence waits until that presence finishes.
// - Unsignalled interrupt stretches the next reset low then sends presence.
// - Alarm during reset low starts a fresh full interrupt pulse.
// - On attach, normal presence first, then extended next reset; the code already extends the first reset if an interrupt is pending.
// - Delay select picks 3.5 ms or 123 ms end-of-activity delay.
// - Alarm exists when a counter equals its alarm register.
// - Active-low enable bits in the status register enable interrupts.
module tkc_control #(
	parameter int RST_CYC        = tkc_pkg::RST_DET_CYC,
	parameter int INT_CYC        = tkc_pkg::INT_LOW_CYC,
	parameter int PRES_LOW_CYC   = tkc_pkg::PRES_LOW_CYC,
	parameter int ACTIVITY_DELAY_SELECT_SHORT_CYC = tkc_pkg::ACTIVITY_DELAY_SELECT_SHORT_CYC,
	parameter int ACTIVITY_DELAY_SELECT_LONG_CYC  = tkc_pkg::ACTIVITY_DELAY_SELECT_LONG_CYC
) (
	// Clock, reset, enable
	input  wire logic              clock,
	input  wire logic              arst_n,
	input  wire logic              clk_en,
	// Data line pin
	input  wire logic              line_in,
	output logic                   line_out,
	output logic                   line_oe_n,
	// Register port from memory function logic
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [9:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              copy_aa,
	output logic [7:0]             reg_rdata,
	// Counter alarm matches
	input  wire logic [2:0]        alarm_match,
	// Status towards counters and memory
	output tkc_pkg::tkc_status_t   status,
	output logic                   activity_end
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_s1;
	logic rst_n;

	// Two-stage release of the asynchronous reset
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end
		else if (clk_en)
		begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	tkc_pkg::tkc_state_t r_reg;
	tkc_pkg::tkc_state_t r_next;
	logic                irq_pending;
	logic                any_wp;
	logic [2:0]          alarm_ev;
	logic                line_nx;
	logic                fell;
	logic [7:0]          wr_cfg;
	logic [23:0]         act_lim;

	// Pending interrupt from unmasked flags
	assign irq_pending = |(r_reg.flags & ~r_reg.ien_n);
	assign any_wp      = |r_reg.cfg[2:0];
	assign alarm_ev    = alarm_match & ~r_reg.match_q;
	assign line_nx     = (r_reg.s2 == r_reg.s3) ? r_reg.s3 : r_reg.line_q;
	assign fell        = r_reg.line_q & ~line_nx;
	assign act_lim     = r_reg.cfg[tkc_pkg::CFG_ACTIVITY_ACTIVITY_DELAY_SELECT] ? 24'(ACTIVITY_DELAY_SELECT_LONG_CYC) : 24'(ACTIVITY_DELAY_SELECT_SHORT_CYC);

	// Ordinary config write with protection applied
	always_comb
	begin
		wr_cfg = reg_wdata;
		wr_cfg[2:0] = r_reg.cfg[2:0];
		if (any_wp)
		begin
			wr_cfg[tkc_pkg::CFG_EXPIRE_READ_ONLY] = r_reg.cfg[tkc_pkg::CFG_EXPIRE_READ_ONLY];
			wr_cfg[tkc_pkg::CFG_OSC_ENABLE] = r_reg.cfg[tkc_pkg::CFG_OSC_ENABLE] | reg_wdata[4];
		end
		if (r_reg.cfg[tkc_pkg::CFG_CYCLE_PROTECT])
			wr_cfg[tkc_pkg::CFG_ACTIVITY_ACTIVITY_DELAY_SELECT] = r_reg.cfg[tkc_pkg::CFG_ACTIVITY_ACTIVITY_DELAY_SELECT];
		if (r_reg.cfg[tkc_pkg::CFG_INTERVAL_PROTECT])
			wr_cfg[tkc_pkg::CFG_TIMER_TIMER_AUTO_MANUAL] = r_reg.cfg[tkc_pkg::CFG_TIMER_TIMER_AUTO_MANUAL];
	end

	// Next state
	always_comb
	begin
		r_next = r_reg;
		r_next.s1 = line_in;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		r_next.line_q = line_nx;
		r_next.match_q = alarm_match;
		r_next.act_pulse = 1'b0;

		// End-of-activity detection on long low time
		if (line_nx)
		begin
			r_next.act_cnt = 24'h000000;
			r_next.act_done = 1'b0;
		end
		else if (!r_reg.act_done)
		begin
			r_next.act_cnt = r_reg.act_cnt + 24'h000001;
			if (r_next.act_cnt >= act_lim)
			begin
				r_next.act_done = 1'b1;
				r_next.act_pulse = 1'b1;
			end
		end

		// Register reads; status read clears flags
		if (reg_rd)
		begin
			if (r_reg.expired && !r_reg.cfg[tkc_pkg::CFG_EXPIRE_READ_ONLY])
				r_next.rd_data = 8'h00;
			else if (reg_addr == tkc_pkg::ALARM_STATUS_ADDR)
			begin
				r_next.rd_data = {2'h0, r_reg.ien_n, r_reg.flags};
				r_next.flags = 3'h0;
			end
			else if (reg_addr == tkc_pkg::TIMER_CONFIG_ADDR)
				r_next.rd_data = r_reg.cfg;
			else
				r_next.rd_data = 8'h00;
		end

		// Register writes, blocked after expiration
		if (reg_wr && !r_reg.expired)
		begin
			if (reg_addr == tkc_pkg::ALARM_STATUS_ADDR)
			begin
				r_next.ien_n = reg_wdata[5:3];
				r_next.copy_cnt = 2'h0;
			end
			else if (reg_addr == tkc_pkg::TIMER_CONFIG_ADDR)
			begin
				r_next.cfg = wr_cfg;
				// Count repeated authorized copies of the same byte
				if (copy_aa && r_reg.copy_cnt != 2'h0 && reg_wdata == r_reg.copy_data)
				begin
					r_next.copy_cnt = r_reg.copy_cnt + 2'h1;
					if (r_reg.copy_cnt == tkc_pkg::COPY_LAST)
					begin
						r_next.copy_cnt = 2'h0;
						if (!any_wp)
							r_next.cfg[2:0] = reg_wdata[2:0];
					end
				end
				else
				begin
					r_next.copy_cnt = 2'h1;
					r_next.copy_data = reg_wdata;
				end
			end
			else
				r_next.copy_cnt = 2'h0;
		end
		if (r_next.cfg[tkc_pkg::CFG_INTERVAL_PROTECT])
			r_next.cfg[tkc_pkg::CFG_TIMER_STOP_START] = 1'b0;

		// Alarm flags, set wins over read clear
		r_next.flags = r_next.flags | alarm_ev;
		if (|alarm_ev)
			r_next.spont_done = 1'b0;
		if (|(r_reg.cfg[2:0] & alarm_ev))
			r_next.expired = 1'b1;

		// Data line sequencer
		r_next.cnt = r_reg.cnt + 24'h000001;
		case (r_reg.line_st)
			tkc_pkg::LN_IDLE:
			begin
				if (fell)
				begin
					r_next.line_st = tkc_pkg::LN_RST_LOW;
					r_next.cnt = 24'h000000;
					r_next.armed = 1'b0;
					r_next.pend_at_fall = irq_pending;
					r_next.ext_done = 1'b0;
				end
				else if (r_reg.armed && irq_pending && !r_reg.spont_done)
				begin
					r_next.line_st = tkc_pkg::LN_INT_LOW;
					r_next.cnt = 24'h000000;
					r_next.spont_done = 1'b1;
					r_next.armed = 1'b0;
					r_next.master_rst = 1'b0;
				end
			end
			tkc_pkg::LN_RST_LOW:
			begin
				if (line_nx)
				begin
					r_next.cnt = 24'h000000;
					r_next.master_rst = 1'b1;
					r_next.line_st = (r_reg.cnt >= 24'(RST_CYC)) ? tkc_pkg::LN_PRES_WAIT : tkc_pkg::LN_IDLE;
				end
				else if (r_reg.cnt >= 24'(RST_CYC) && irq_pending && !r_reg.ext_done)
				begin
					r_next.line_st = tkc_pkg::LN_INT_LOW;
					r_next.ext_done = 1'b1;
					r_next.spont_done = 1'b1;
					r_next.master_rst = 1'b1;
					if (!r_reg.pend_at_fall)
						r_next.cnt = 24'h000000;
				end
			end
			tkc_pkg::LN_INT_LOW:
			begin
				if (r_reg.cnt >= 24'(INT_CYC - 1))
					r_next.line_st = tkc_pkg::LN_RELEASE;
			end
			tkc_pkg::LN_RELEASE:
			begin
				r_next.cnt = 24'h000000;
				if (line_nx)
					r_next.line_st = tkc_pkg::LN_PRES_WAIT;
			end
			tkc_pkg::LN_PRES_WAIT:
			begin
				if (r_reg.cnt >= 24'(tkc_pkg::PRES_WAIT_CYC - 1))
				begin
					r_next.line_st = tkc_pkg::LN_PRES_LOW;
					r_next.cnt = 24'h000000;
				end
			end
			tkc_pkg::LN_PRES_LOW:
			begin
				if (r_reg.cnt >= 24'(PRES_LOW_CYC - 1))
				begin
					r_next.line_st = tkc_pkg::LN_PRES_HIGH;
					r_next.cnt = 24'h000000;
				end
			end
			tkc_pkg::LN_PRES_HIGH:
			begin
				if (fell)
				begin
					r_next.line_st = tkc_pkg::LN_RST_LOW;
					r_next.cnt = 24'h000000;
					r_next.pend_at_fall = irq_pending;
					r_next.ext_done = 1'b0;
				end
				else if (r_reg.cnt >= 24'(tkc_pkg::PRES_HIGH_CYC - 1))
				begin
					r_next.line_st = tkc_pkg::LN_IDLE;
					r_next.armed = r_reg.master_rst;
				end
			end
			default:
				r_next.line_st = tkc_pkg::LN_IDLE;
		endcase
		r_next.drive_n = !(r_next.line_st == tkc_pkg::LN_INT_LOW || r_next.line_st == tkc_pkg::LN_PRES_LOW);
	end


	// State register
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r_reg          <= '0;
			r_reg.s1       <= 1'b1;
			r_reg.s2       <= 1'b1;
			r_reg.s3       <= 1'b1;
			r_reg.line_q   <= 1'b1;
			r_reg.line_st  <= tkc_pkg::LN_IDLE;
			r_reg.cfg      <= tkc_pkg::TIMER_CONFIG_RESET;
			r_reg.ien_n    <= tkc_pkg::IRQ_ENABLE_N_RESET;
			r_reg.act_done <= 1'b1;
			r_reg.drive_n  <= 1'b1;
		end
		else if (clk_en)
			r_reg <= r_next;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign line_out  = 1'b0;          // Open drain: only ever pulls low
	assign line_oe_n = r_reg.drive_n;
	assign reg_rdata = r_reg.rd_data;
	assign activity_end = r_reg.act_pulse;

	// Counting gates and access permissions
	always_comb
	begin
		status.osc_run = r_reg.cfg[tkc_pkg::CFG_OSC_ENABLE];
		status.interval_run = r_reg.cfg[tkc_pkg::CFG_OSC_ENABLE] &
			(r_reg.cfg[tkc_pkg::CFG_TIMER_TIMER_AUTO_MANUAL] ? r_reg.line_q
			: ~r_reg.cfg[tkc_pkg::CFG_TIMER_STOP_START]);
		status.counter_write_ok = ~r_reg.cfg[2:0] & {3{~r_reg.expired}};
		status.mem_write_ok = ~r_reg.expired;
		status.mem_read_ok = ~r_reg.expired | r_reg.cfg[tkc_pkg::CFG_EXPIRE_READ_ONLY];
		status.expired = r_reg.expired;
		status.irq_pending = irq_pending;
	end

endmodule : tkc_control

// ### test/tkc_control_assertions.sv
// Checker for the timekeeper control block: line pulses, status flags, protection.
// Assumes it is bound to tkc_control and sees only that module's ports.
`timescale 1ns/1ps
module tkc_control_assertions #(
	parameter int RST_CYC        = 50,
	parameter int INT_CYC        = 120,
	parameter int PRES_LOW_CYC   = 12,
	parameter int ACTIVITY_DELAY_SELECT_SHORT_CYC = 40,
	parameter int ACTIVITY_DELAY_SELECT_LONG_CYC  = 80
) (
	// Clock and reset
	input wire logic                 clock,
	input wire logic                 arst_n,
	// Watched ports
	input wire logic                 line_oe_n,
	input wire logic                 reg_wr,
	input wire logic                 reg_rd,
	input wire logic [9:0]           reg_addr,
	input wire logic [7:0]           reg_rdata,
	input wire logic [2:0]           alarm_match,
	input wire tkc_pkg::tkc_status_t status,
	input wire logic                 activity_end
);
	logic [23:0] lo_cnt;
	logic        rd_sts;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	// Readable status access
	assign rd_sts = reg_rd && reg_addr == tkc_pkg::ALARM_STATUS_ADDR && status.mem_read_ok;

	// Length of the current device low
	always_ff @(posedge clock or negedge arst_n)
		if (!arst_n)
			lo_cnt <= 24'h000000;
		else if (line_oe_n)
			lo_cnt <= 24'h000000;
		else
			lo_cnt <= lo_cnt + 24'h000001;

	// ----------------
	// Assertions
	// ----------------
	AST_PULSE_LEN: assert property ($rose(line_oe_n) |-> (lo_cnt >= PRES_LOW_CYC - 1 && lo_cnt <= PRES_LOW_CYC + 1)
		|| (lo_cnt >= INT_CYC - RST_CYC - 2 && lo_cnt <= INT_CYC + 1)) else $error("device low length");
	AST_STS_CLEAR: assert property ((rd_sts && $stable(alarm_match)) ##1 $stable(alarm_match) ##1
		(rd_sts && $stable(alarm_match)) |=> reg_rdata[2:0] == 3'h0) else $error("flags not cleared");
	AST_IRQ_HOLD: assert property (status.irq_pending && !reg_rd && !reg_wr |=> status.irq_pending)
		else $error("pending lost");
	AST_OSC_GATE: assert property (!status.osc_run |-> !status.interval_run)
		else $error("timer runs without oscillator");
	AST_OSC_HOLD: assert property (status.osc_run && status.counter_write_ok != 3'h7 |=> status.osc_run)
		else $error("oscillator stopped");
	AST_PROT_KEEP: assert property (1'b1 |=> (status.counter_write_ok & ~$past(status.counter_write_ok)) == 3'h0)
		else $error("protection undone");
	AST_EXP_STICKY: assert property (status.expired |=> status.expired)
		else $error("expiry undone");
	AST_EXP_WR: assert property (status.expired |-> !status.mem_write_ok && status.counter_write_ok == 3'h0)
		else $error("write after expiry");
	AST_LIVE: assert property (!status.expired |-> status.mem_read_ok && status.mem_write_ok)
		else $error("access limited early");
	AST_ACT_PULSE: assert property (activity_end |=> !activity_end)
		else $error("activity pulse long");

	COV_LONG_LOW: cover property ($rose(line_oe_n) && lo_cnt > PRES_LOW_CYC + 1);
	COV_EXPIRED: cover property ($rose(status.expired));
	COV_ACTIVITY: cover property (activity_end);
endmodule : tkc_control_assertions

bind tkc_control tkc_control_assertions #(.RST_CYC(RST_CYC), .INT_CYC(INT_CYC), .PRES_LOW_CYC(PRES_LOW_CYC),
	.ACTIVITY_DELAY_SELECT_SHORT_CYC(ACTIVITY_DELAY_SELECT_SHORT_CYC), .ACTIVITY_DELAY_SELECT_LONG_CYC(ACTIVITY_DELAY_SELECT_LONG_CYC)) tkc_control_assertions_inst (
	.clock(clock), .arst_n(arst_n), .line_oe_n(line_oe_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_rdata(reg_rdata), .alarm_match(alarm_match), .status(status),
	.activity_end(activity_end));

// ### test/tkc_line_master.sv
// Bus master model on the single data line: reset pulses and pulse timing.
// Assumes an open-drain line with pull-up; the device pulls low while line_oe_n is low.
`timescale 1ns/1ps
module tkc_line_master (
	// Clock
	input wire logic clock,
	// Line
	input wire logic line_oe_n,
	output logic     line
);
	logic drv_low = 1'b0;

	// Pull-up unless a party pulls low
	assign line = !drv_low && line_oe_n;

	// Wait for a low, then count its cycles
	task automatic low_len(input int lim, output int n);
		int w;
		w = 0;
		n = 0;
		while (line && w++ < lim) @(negedge clock);
		while (!line && n++ < lim) @(negedge clock);
	endtask : low_len

	// Reset pulse, then stretch length and presence length
	task automatic rst_pulse(input int lo, output int ext, output int pres);
		ext = 0;
		drv_low = 1'b1;
		repeat (lo) @(negedge clock);
		drv_low = 1'b0;
		#1;
		while (!line && ext++ < 5000) @(negedge clock);
		low_len(5000, pres);
	endtask : rst_pulse
endmodule : tkc_line_master

// ### test/tkc_control_tb_top.sv
// Self-checking bench for the timekeeper control block.
// Assumes tkc_pkg, tkc_control, the line master and the bound checker.
`timescale 1ns/1ps
module tkc_control_tb_top;
	localparam logic [9:0] STS = tkc_pkg::ALARM_STATUS_ADDR;
	localparam logic [9:0] CFG = tkc_pkg::TIMER_CONFIG_ADDR;
	localparam int IC = 120;
	localparam int PC = 12;
	logic                 clock       = 1'b0;
	logic                 arst_n      = 1'b0;
	logic                 clk_en      = 1'b1;
	logic                 reg_wr      = 1'b0;
	logic                 reg_rd      = 1'b0;
	logic                 copy_aa     = 1'b0;
	logic [9:0]           reg_addr    = 10'h000;
	logic [7:0]           reg_wdata   = 8'h00;
	logic [2:0]           alarm_match = 3'h0;
	logic [7:0]           reg_rdata;
	logic                 line;
	logic                 line_oe_n;
	logic                 activity_end;
	tkc_pkg::tkc_status_t status;
	int                   n_mismatch  = 0;
	int                   checked     = 0;
	int                   n_act       = 0;
	int                   e;
	int                   p;
	int                   n;

	always #5 clock = ~clock;

	// Count activity-end pulses away from the launching edge
	always @(negedge clock)
		if (activity_end === 1'b1)
			n_act++;

	tkc_control #(.RST_CYC(50), .INT_CYC(IC), .PRES_LOW_CYC(PC), .ACTIVITY_DELAY_SELECT_SHORT_CYC(40), .ACTIVITY_DELAY_SELECT_LONG_CYC(80))
	tkc_control_inst (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .line_in(line), .line_out(),
		.line_oe_n(line_oe_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.copy_aa(copy_aa), .reg_rdata(reg_rdata), .alarm_match(alarm_match), .status(status),
		.activity_end(activity_end));
	tkc_line_master tkc_line_master_inst (.clock(clock), .line_oe_n(line_oe_n), .line(line));

	// ----------------
	// Shared tasks
	// ----------------
	task automatic cmp(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("ERROR t=%0t %s", $time, m);
		end
	endtask : cmp

	task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic aa);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		copy_aa = aa;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [9:0] a, input logic [7:0] x, input string m);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		cmp(reg_rdata === x, m);
	endtask : rd

	task automatic alarm(input logic [2:0] m);
		@(negedge clock);
		alarm_match = m;
		repeat (2) @(negedge clock);
		alarm_match = 3'h0;
		repeat (2) @(negedge clock);
	endtask : alarm

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up

	// ----------------
	// Scenarios
	// ----------------
	task automatic t_regs();
		rd(CFG, 8'h00, "cfg reset");
		rd(STS, 8'h38, "sts reset");
		wr(CFG, 8'h37, 1'b0);
		rd(CFG, 8'h30, "plain write");
		cmp(status.interval_run === 1'b1, "auto");
		wr(CFG, 8'h50, 1'b0);
		cmp(status.interval_run === 1'b0, "stopped");
		wr(CFG, 8'h70, 1'b0);
		cmp(status.interval_run === 1'b1, "auto stop");
		wr(CFG, 8'h00, 1'b0);
		clk_en = 1'b0;
		wr(CFG, 8'h10, 1'b0);
		clk_en = 1'b1;
		rd(CFG, 8'h00, "enable low freezes");
		alarm(3'h1);
		rd(STS, 8'h39, "flag");
		rd(STS, 8'h38, "clear");
		cmp(status.expired === 1'b0, "no expiry");
		$display("test regs done");
	endtask : t_regs

	task automatic t_irq();
		wr(STS, 8'h30, 1'b0);
		alarm(3'h1);
		cmp(status.irq_pending === 1'b1, "pending");
		tkc_line_master_inst.rst_pulse(60, e, p);
		cmp(e >= IC - 62 && e <= IC - 52, "stretch");
		cmp(p >= PC - 1 && p <= PC + 1, "presence");
		rd(STS, 8'h31, "ack");
		n = n_act;
		tkc_line_master_inst.rst_pulse(60, e, p);
		cmp(e == 0, "acked");
		cmp(n_act == n + 1, "short delay");
		repeat (3100) @(negedge clock);
		@(negedge clock);
		alarm_match = 3'h1;
		tkc_line_master_inst.low_len(400, n);
		alarm_match = 3'h0;
		cmp(n >= IC - 2 && n <= IC + 2, "spont");
		tkc_line_master_inst.low_len(5000, n);
		cmp(n >= PC - 1 && n <= PC + 1, "spont presence");
		tkc_line_master_inst.low_len(6000, n);
		cmp(n == 0, "once");
		rd(STS, 8'h31, "ack spont");
		wr(CFG, 8'h80, 1'b0);
		n = n_act;
		tkc_line_master_inst.rst_pulse(60, e, p);
		cmp(n_act == n, "long delay");
		wr(CFG, 8'h00, 1'b0);
		repeat (3100) @(negedge clock);
		tkc_line_master_inst.rst_pulse(5, e, p);
		alarm(3'h1);
		tkc_line_master_inst.low_len(4000, n);
		cmp(n == 0, "disarmed");
		tkc_line_master_inst.rst_pulse(60, e, p);
		cmp(e >= IC - 62 && e <= IC - 52, "late stretch");
		rd(STS, 8'h31, "ack late");
		// Alarm arrives while the master still holds reset low
		fork
			tkc_line_master_inst.rst_pulse(60, e, p);
			begin
				repeat (20) @(negedge clock);
				alarm_match = 3'h1;
			end
		join
		alarm_match = 3'h0;
		cmp(e >= IC - 10 && e <= IC, "fresh pulse");
		cmp(p >= PC - 1 && p <= PC + 1, "fresh presence");
		rd(STS, 8'h31, "ack fresh");
		// Alarm during presence recovery waits for it to finish
		alarm(3'h1);
		tkc_line_master_inst.low_len(400, n);
		cmp(n == 0, "held for presence");
		tkc_line_master_inst.low_len(4000, n);
		cmp(n >= IC - 2 && n <= IC + 2, "after presence");
		rd(STS, 8'h31, "ack held");
		$display("test irq done");
	endtask : t_irq

	task automatic t_protect();
		wr(CFG, 8'h56, 1'b0);
		wr(CFG, 8'h56, 1'b1);
		cmp(status.counter_write_ok === 3'h7, "early");
		wr(CFG, 8'h56, 1'b1);
		rd(CFG, 8'h16, "protect");
		cmp(status.counter_write_ok === 3'h1, "locked");
		repeat (3) wr(CFG, 8'he9, 1'b1);
		rd(CFG, 8'h16, "frozen");
		alarm(3'h2);
		cmp(status.expired === 1'b1, "expired");
		rd(CFG, 8'h00, "rom only");
		$display("test protect done");
	endtask : t_protect

	// Watchdog
	initial
	begin
		#1000000;
		n_mismatch++;
		wrap_up();
	end

	// Main sequence
	initial
	begin
		repeat (20) @(negedge clock);
		arst_n = 1'b1;
		repeat (3) @(negedge clock);
		t_regs();
		t_irq();
		t_protect();
		wrap_up();
	end
endmodule : tkc_control_tb_top
